// ===== pcce_pkg.sv
// Package for the per-channel canceller enable control: register map, fields and codes
package pcce_pkg;
  // Channel count
  localparam int NumChan = 24;
  // AXI4-Lite byte offsets
  localparam logic [7:0] OffCtrl = 8'h00;
  localparam logic [7:0] OffForceByp = 8'h04;
  localparam logic [7:0] OffForceAct = 8'h08;
  localparam logic [7:0] OffManDis = 8'h0C;
  localparam logic [7:0] OffCcsBusy = 8'h10;
  localparam logic [7:0] OffEnState = 8'h14;
  localparam logic [7:0] OffSelfTest = 8'h18;
  localparam logic [7:0] OffIrqStat = 8'h1C;
  localparam logic [7:0] OffIrqClr = 8'h20;
  localparam logic [7:0] OffIrqEn = 8'h24;
  localparam logic [7:0] OffFaultByp = 8'h28;
  // Control register fields
  localparam int CtrlMethodLsb = 0; // 2 bits: 0 robbed-bit, 1/2 idle code
  localparam int CtrlIdleSelLsb = 2; // 2 bits: 0 7F, 1 F7, 2 FF
  localparam int CtrlIdleLogLsb = 4; // 2 bits: OR, AND, send, receive
  localparam int CtrlCasLogLsb = 6; // 2 bits: OR, AND, send, receive
  localparam int CtrlCardLsb = 8; // 3 bits: card type
  localparam int CtrlFaultAis = 11; // 1 = alarm indication on fault
  localparam int CtrlSigDisEn = 12; // 1 = signaling tone disabler on
  localparam logic [31:0] CtrlReset = 32'h0000_0000;
  // Idle channel byte values
  localparam logic [7:0] Idle7F = 8'h7F;
  localparam logic [7:0] IdleF7 = 8'hF7;
  localparam logic [7:0] IdleFF = 8'hFF;
  // Send-in / receive-in idle A/B pairs, {A,B}
  localparam logic [1:0] IdleEmSnd = 2'h0;
  localparam logic [1:0] IdleEmRcv = 2'h0;
  localparam logic [1:0] IdleFxoGsSnd = 2'h3;
  localparam logic [1:0] IdleFxoGsRcv = 2'h1;
  localparam logic [1:0] IdleFxsGsSnd = 2'h1;
  localparam logic [1:0] IdleFxsGsRcv = 2'h3;
  localparam logic [1:0] IdleLsSnd = 2'h1;
  localparam logic [1:0] IdleLsRcv = 2'h1;
  // Interrupt status bits
  localparam int IrqGoBusy = 0;
  localparam int IrqGoIdle = 1;
  localparam int IrqFault = 2;
  localparam int IrqStFail = 3;
  localparam int IrqWidth = 4;
  // Card types
  typedef enum logic [2:0] {CardEm, CardFxoGs, CardFxsGs, CardFxoLs, CardFxsLs} pcce_card_t;
  // Two-way combining logic
  typedef enum logic [1:0] {LogOr, LogAnd, LogSend, LogRecv} pcce_logic_t;
endpackage

// ===== pcce_channel_ctrl.sv
// Per-channel busy/idle decision, fault handling and AXI4-Lite register slave
`timescale 1ns/1ps
module pcce_channel_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  // Per-channel sample strobe and signalling
  input wire logic sampleValid,
  input wire logic [4:0] sampleChan,
  input wire logic [1:0] sendAb,
  input wire logic [1:0] recvAb,
  input wire logic [7:0] sendByte,
  input wire logic [7:0] recvByte,
  input wire logic toneNo5,
  input wire logic toneVpc,
  input wire logic toneSf,
  input wire logic dataTone,
  input wire logic sysFault,
  input wire logic holdActive,
  input wire logic selfTestFail,
  // Common-channel commands from the serial_comm_port
  input wire logic ccsValid,
  input wire logic [4:0] ccsChan,
  input wire logic ccsBusy,
  // Outputs
  output logic [23:0] cancelEn,
  output logic [23:0] selfTestRun,
  output logic [23:0] chanBypass,
  output logic aisOut,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Two-way combining of send and receive conditions
  function automatic logic combine(input logic [1:0] sel, input logic s, input logic r);
    case (sel)
      2'h0: combine = s | r;
      2'h1: combine = s & r;
      2'h2: combine = s;
      default: combine = r;
    endcase
  endfunction

  // Apply byte enables to a 32-bit register
  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    wmask = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] ctrl_q; // Mode control
  logic [23:0] forceByp_q; // Forced bypass per channel
  logic [23:0] forceAct_q; // Forced active per channel
  logic [23:0] manDis_q; // manual_channel_disable_setting
  logic [23:0] ccsBusy_q; // Common-channel busy state
  logic [23:0] ccsSet_q; // Common-channel command seen since reset
  logic [23:0] monBusy_q; // Monitored busy state, one per channel
  logic [23:0] stFail_q; // Latched self-test failure per channel
  logic [pcce_pkg::IrqWidth-1:0] irqStat_q; // Sticky event status
  logic [pcce_pkg::IrqWidth-1:0] irqEn_q; // Interrupt enables
  logic [pcce_pkg::IrqWidth-1:0] irqSet; // Events of this cycle
  logic [23:0] cancelEn_d;
  logic [23:0] bypass_d;
  logic aisOut_d;

  // Bus handshake state
  logic awHave_q, wHave_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wrFire, rdFire;
  logic [31:0] rdData;
  logic rdOk;

  // Decoded control fields
  logic [1:0] method, idleSel, idleLog, casLog;
  pcce_pkg::pcce_card_t card;
  assign method = ctrl_q[pcce_pkg::CtrlMethodLsb +: 2];
  assign idleSel = ctrl_q[pcce_pkg::CtrlIdleSelLsb +: 2];
  assign idleLog = ctrl_q[pcce_pkg::CtrlIdleLogLsb +: 2];
  assign casLog = ctrl_q[pcce_pkg::CtrlCasLogLsb +: 2];
  assign card = pcce_pkg::pcce_card_t'(ctrl_q[pcce_pkg::CtrlCardLsb +: 3]);

  ////////////////////////////////////////////////////////////////////////////
  // Monitor decision for the channel now being sampled

  logic sndIdleAb, rcvIdleAb, sndIdleCode, rcvIdleCode;
  logic [7:0] idleByte;
  logic sampleBusy;
  logic inRange;
  assign inRange = sampleChan < 5'd24;

  // Idle A/B pattern match per card type
  always_comb begin
    case (card)
      pcce_pkg::CardEm: begin
        sndIdleAb = sendAb == pcce_pkg::IdleEmSnd;
        rcvIdleAb = recvAb == pcce_pkg::IdleEmRcv;
      end
      pcce_pkg::CardFxoGs: begin
        sndIdleAb = sendAb == pcce_pkg::IdleFxoGsSnd;
        rcvIdleAb = recvAb == pcce_pkg::IdleFxoGsRcv;
      end
      pcce_pkg::CardFxsGs: begin
        sndIdleAb = sendAb == pcce_pkg::IdleFxsGsSnd;
        rcvIdleAb = recvAb == pcce_pkg::IdleFxsGsRcv;
      end
      default: begin
        // Both loop-start cards share one idle pair
        sndIdleAb = sendAb == pcce_pkg::IdleLsSnd;
        rcvIdleAb = recvAb == pcce_pkg::IdleLsRcv;
      end
    endcase
  end

  // Idle byte selection
  always_comb begin
    case (idleSel)
      2'h0: idleByte = pcce_pkg::Idle7F;
      2'h1: idleByte = pcce_pkg::IdleF7;
      default: idleByte = pcce_pkg::IdleFF;
    endcase
  end
  assign sndIdleCode = sendByte == idleByte;
  assign rcvIdleCode = recvByte == idleByte;

  // Method select: robbed-bit watches busy, idle code ignores A/B
  always_comb begin
    if (method == 2'h0) begin
      // Busy combining applies to busy sides
      sampleBusy = combine(casLog, ~sndIdleAb, ~rcvIdleAb);
    end else begin
      // Disabled when idle code combination holds
      sampleBusy = ~combine(idleLog, sndIdleCode, rcvIdleCode);
    end
  end

  // Per-channel monitored state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      monBusy_q <= 24'h000000;
    end else if (clkEn && sampleValid && inRange) begin
      monBusy_q[sampleChan] <= sampleBusy;
    end
  end

  // Common-channel commands, taken in every method
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ccsBusy_q <= 24'h000000;
      ccsSet_q <= 24'h000000;
    end else if (clkEn && ccsValid && ccsChan < 5'd24) begin
      ccsBusy_q[ccsChan] <= ccsBusy;
      ccsSet_q[ccsChan] <= 1'b1;
    end
  end

  // Self-test failure latch, cleared when the channel goes busy
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stFail_q <= 24'h000000;
    end else if (clkEn && sampleValid && inRange) begin
      stFail_q[sampleChan] <= ~sampleBusy & (stFail_q[sampleChan] | selfTestFail);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority resolution

  logic toneHit;
  // Signaling tones only when the disabler is on; data tones always
  assign toneHit = dataTone | (ctrl_q[pcce_pkg::CtrlSigDisEn] & (toneNo5 | toneVpc | toneSf));

  always_comb begin
    aisOut_d = 1'b0;
    for (int c = 0; c < pcce_pkg::NumChan; c++) begin
      logic en;
      logic byp;
      en = monBusy_q[c];
      byp = 1'b0;
      // Lowest to highest, each overrides the one before
      if (ccsSet_q[c]) begin
        en = ccsBusy_q[c];
      end
      if (forceAct_q[c]) begin
        en = 1'b1;
      end
      if (forceByp_q[c] | manDis_q[c]) begin
        en = 1'b0;
      end
      if (toneHit) begin
        en = 1'b0;
      end
      if (sysFault) begin
        en = 1'b0;
        // With alarm indication on, only failing channels bypass under hold; with it off every channel bypasses
        if (!ctrl_q[pcce_pkg::CtrlFaultAis]) begin
          byp = 1'b1;
        end else if (holdActive) begin
          byp = stFail_q[c];
        end
      end
      cancelEn_d[c] = en;
      bypass_d[c] = byp;
    end
    aisOut_d = sysFault & ctrl_q[pcce_pkg::CtrlFaultAis] & ~holdActive;
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cancelEn <= 24'h000000;
      selfTestRun <= 24'h000000;
      chanBypass <= 24'h000000;
      aisOut <= 1'b0;
    end else if (clkEn) begin
      cancelEn <= cancelEn_d;
      selfTestRun <= ~cancelEn_d & ~bypass_d;
      chanBypass <= bypass_d;
      aisOut <= aisOut_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign irqSet[pcce_pkg::IrqGoBusy] = |(cancelEn_d & ~cancelEn);
  assign irqSet[pcce_pkg::IrqGoIdle] = |(~cancelEn_d & cancelEn);
  assign irqSet[pcce_pkg::IrqFault] = sysFault & ~aisOut & ~chanBypass[0];
  assign irqSet[pcce_pkg::IrqStFail] = selfTestFail & sampleValid;

  // Sticky status, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqStat_q <= '0;
    end else if (clkEn) begin
      if (wrFire && awAddr_q == pcce_pkg::OffIrqClr) begin
        irqStat_q <= (irqStat_q & ~wData_q[pcce_pkg::IrqWidth-1:0]) | irqSet;
      end else begin
        irqStat_q <= irqStat_q | irqSet;
      end
    end
  end
  assign irq = |(irqStat_q & irqEn_q);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign s_axi_awready = ~awHave_q & ~s_axi_bvalid;
  assign s_axi_wready = ~wHave_q & ~s_axi_bvalid;
  assign wrFire = awHave_q & wHave_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rdFire = clkEn & s_axi_arvalid & s_axi_arready;

  // Write capture and response
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_q <= pcce_pkg::OffFaultByp && awAddr_q[1:0] == 2'h0 &&
                        awAddr_q != pcce_pkg::OffCcsBusy &&
                        awAddr_q != pcce_pkg::OffEnState && awAddr_q != pcce_pkg::OffSelfTest &&
                        awAddr_q != pcce_pkg::OffIrqStat && awAddr_q != pcce_pkg::OffFaultByp) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= pcce_pkg::CtrlReset;
      forceByp_q <= 24'h000000;
      forceAct_q <= 24'h000000;
      manDis_q <= 24'h000000;
      irqEn_q <= '0;
    end else if (clkEn && wrFire) begin
      case (awAddr_q)
        // Only the held write data counts; the bus may already show the next word
        pcce_pkg::OffCtrl: ctrl_q <= wmask(ctrl_q, wData_q & 32'h0000_1FFF, wStrb_q);
        pcce_pkg::OffForceByp: forceByp_q <= 24'(wmask({8'h00, forceByp_q}, wData_q, wStrb_q));
        pcce_pkg::OffForceAct: forceAct_q <= 24'(wmask({8'h00, forceAct_q}, wData_q, wStrb_q));
        pcce_pkg::OffManDis: manDis_q <= 24'(wmask({8'h00, manDis_q}, wData_q, wStrb_q));
        pcce_pkg::OffIrqEn: irqEn_q <= wData_q[pcce_pkg::IrqWidth-1:0];
        default: ;
      endcase
    end
  end

  // Read decode
  always_comb begin
    rdOk = 1'b1;
    case (s_axi_araddr)
      pcce_pkg::OffCtrl: rdData = ctrl_q;
      pcce_pkg::OffForceByp: rdData = {8'h00, forceByp_q};
      pcce_pkg::OffForceAct: rdData = {8'h00, forceAct_q};
      pcce_pkg::OffManDis: rdData = {8'h00, manDis_q};
      pcce_pkg::OffCcsBusy: rdData = {8'h00, ccsBusy_q};
      pcce_pkg::OffEnState: rdData = {8'h00, cancelEn};
      pcce_pkg::OffSelfTest: rdData = {8'h00, selfTestRun};
      pcce_pkg::OffIrqStat: rdData = {28'h0000000, irqStat_q};
      pcce_pkg::OffIrqClr: rdData = 32'h0000_0000;
      pcce_pkg::OffIrqEn: rdData = {28'h0000000, irqEn_q};
      pcce_pkg::OffFaultByp: rdData = {8'h00, chanBypass};
      default: begin
        rdData = 32'h0000_0000;
        rdOk = 1'b0;
      end
    endcase
  end

  // Read response
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (clkEn) begin
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_fault_bypass: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && sysFault && !ctrl_q[pcce_pkg::CtrlFaultAis] |=> chanBypass == 24'hFFFFFF)
    else $error("Bypass on fault missing");
  a_ais_hold: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && holdActive |=> !aisOut)
    else $error("Alarm output under hold");
  a_tone_off: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && dataTone |=> cancelEn == 24'h000000)
    else $error("Tone did not disable");
  a_manual_dis: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn |=> (cancelEn & $past(manDis_q)) == 24'h000000)
    else $error("Manual disable ignored");
  a_force_act: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && !sysFault && !toneHit && !(|manDis_q) && !(|forceByp_q) |=> (cancelEn & $past(forceAct_q)) == $past(forceAct_q))
    else $error("Forced active ignored");
  a_selftest_idle: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && !sysFault |=> selfTestRun == ~cancelEn)
    else $error("Self-test does not follow idle state");
  a_ccs_take: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && ccsValid && ccsChan == 5'd0 |=> ccsBusy_q[0] == $past(ccsBusy))
    else $error("Common-channel command lost");
  a_mon_store: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && sampleValid && sampleChan == 5'd0 |=> monBusy_q[0] == $past(sampleBusy))
    else $error("Channel state not stored");
  c_fault: cover property (@(posedge clk_sys) sysFault && aisOut);
  c_busy: cover property (@(posedge clk_sys) irqSet[pcce_pkg::IrqGoBusy]);
  c_write: cover property (@(posedge clk_sys) wrFire);

endmodule // pcce_channel_ctrl

// ===== pcce_t1_partner.sv
// Far-side signalling source model: per-channel samples and common-channel commands
`timescale 1ns/1ps
module pcce_t1_partner (
  input wire logic clk_sys,
  output logic sampleValid,
  output logic [4:0] sampleChan,
  output logic [1:0] sendAb,
  output logic [1:0] recvAb,
  output logic [7:0] sendByte,
  output logic [7:0] recvByte,
  output logic selfTestFail,
  output logic ccsValid,
  output logic [4:0] ccsChan,
  output logic ccsBusy
);
  // Strobes low and lines defined from time zero
  initial begin
    sampleValid = 1'h0;
    sampleChan = 5'h00;
    sendAb = 2'h0;
    recvAb = 2'h0;
    sendByte = 8'h00;
    recvByte = 8'h00;
    selfTestFail = 1'h0;
    ccsValid = 1'h0;
    ccsChan = 5'h00;
    ccsBusy = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One channel slot; qualifiers only valid during the strobe cycle
  task automatic sendSample(input logic [4:0] ch, input logic [1:0] sa, input logic [1:0] ra,
                            input logic [7:0] sb, input logic [7:0] rb, input logic fail);
    @(posedge clk_sys);
    sampleValid <= 1'h1;
    sampleChan <= ch;
    sendAb <= sa;
    recvAb <= ra;
    sendByte <= sb;
    recvByte <= rb;
    selfTestFail <= fail;
    @(posedge clk_sys);
    sampleValid <= 1'h0;
    // Released slot shows the inverse, so a stale copy can never pass for a sample
    sendAb <= ~sa;
    recvAb <= ~ra;
    sendByte <= ~sb;
    recvByte <= ~rb;
    selfTestFail <= ~fail;
  endtask

  // One busy/idle command from the serial_comm_port
  task automatic sendCcs(input logic [4:0] ch, input logic busy);
    @(posedge clk_sys);
    ccsValid <= 1'h1;
    ccsChan <= ch;
    ccsBusy <= busy;
    @(posedge clk_sys);
    ccsValid <= 1'h0;
    ccsChan <= ~ch;
    ccsBusy <= ~busy;
  endtask
endmodule // pcce_t1_partner

// ===== tb_per_channel_canceller_enable_control.sv
// Self-checking bench for the per-channel canceller enable control
`timescale 1ns/1ps
module tb_per_channel_canceller_enable_control;
  // Table row: control word, channel, A/B pairs, channel bytes, expected enable
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0] ch;
    logic [3:0] sa;
    logic [3:0] ra;
    logic [7:0] sb;
    logic [7:0] rb;
    logic [3:0] en;
  } pcce_row_t;
  logic clk_sys, reset, clkEn, dataTone, sysFault, holdActive;
  logic [2:0] tones; // No. 5, path check, single frequency
  logic sampleValid, selfTestFail, ccsValid, ccsBusy, aisOut, irq;
  logic [4:0] sampleChan, ccsChan;
  logic [1:0] sendAb, recvAb, bResp, rResp, resp;
  logic [7:0] sendByte, recvByte, awAddr, arAddr;
  logic [23:0] cancelEn, selfTestRun, chanBypass, expVec;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [31:0] wData, rData, rd;
  int numErrors = 0;
  int nCompared = 0;
  int cyc = 0;
  logic [7:0] rstOffs [5] = '{pcce_pkg::OffCtrl, pcce_pkg::OffForceByp, pcce_pkg::OffForceAct,
                              pcce_pkg::OffManDis, pcce_pkg::OffIrqEn};
  // Each busy row precedes its idle row so that every check sees a change
  pcce_row_t rows [24] = '{
    52'h0000_00_3_3_00_00_1, 52'h0000_00_0_0_00_00_0, 52'h0000_01_3_0_00_00_1, 52'h0040_01_3_0_00_00_0,
    52'h0080_01_3_0_00_00_1, 52'h00C0_01_3_0_00_00_0, 52'h0100_02_0_0_00_00_1, 52'h0100_02_3_1_00_00_0,
    52'h0200_03_0_0_00_00_1, 52'h0200_03_1_3_00_00_0, 52'h0300_04_0_0_00_00_1, 52'h0300_04_1_1_00_00_0,
    52'h0400_05_0_0_00_00_1, 52'h0400_05_1_1_00_00_0, 52'h0001_06_0_0_00_00_1, 52'h0001_06_0_0_7F_00_0,
    52'h0011_06_0_0_7F_00_1, 52'h0011_06_0_0_7F_7F_0, 52'h0021_06_0_0_00_7F_1, 52'h0031_06_0_0_00_7F_0,
    52'h0006_07_0_0_7F_7F_1, 52'h0006_07_0_0_F7_F7_0, 52'h000A_08_0_0_F7_F7_1, 52'h000A_08_0_0_FF_FF_0};

  pcce_channel_ctrl u_pcce_channel_ctrl (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
    .sampleValid(sampleValid), .sampleChan(sampleChan), .sendAb(sendAb), .recvAb(recvAb),
    .sendByte(sendByte), .recvByte(recvByte), .toneNo5(tones[0]), .toneVpc(tones[1]), .toneSf(tones[2]),
    .dataTone(dataTone), .sysFault(sysFault), .holdActive(holdActive), .selfTestFail(selfTestFail),
    .ccsValid(ccsValid), .ccsChan(ccsChan), .ccsBusy(ccsBusy), .cancelEn(cancelEn),
    .selfTestRun(selfTestRun), .chanBypass(chanBypass), .aisOut(aisOut), .irq(irq),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady));

  pcce_t1_partner u_pcce_t1_partner (.clk_sys(clk_sys), .sampleValid(sampleValid), .sampleChan(sampleChan),
    .sendAb(sendAb), .recvAb(recvAb), .sendByte(sendByte), .recvByte(recvByte), .selfTestFail(selfTestFail),
    .ccsValid(ccsValid), .ccsChan(ccsChan), .ccsBusy(ccsBusy));

  ////////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Cycle ceiling: the sequence needs well under 3000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      numErrors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nCompared++;
    if (s !== e) begin
      numErrors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b;
    b = 1'h0;
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    while (!b) begin
      @(posedge clk_sys);
      if (awValid && awReady) awValid <= 1'h0;
      if (wValid && wReady) wValid <= 1'h0;
      if (bValid) begin
        b = 1'h1;
        r = bResp;
        bReady <= 1'h0;
      end
    end
  endtask

  // Read: address held until taken, data taken with rvalid
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic b;
    b = 1'h0;
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= 1'h1;
    while (!b) begin
      @(posedge clk_sys);
      if (arValid && arReady) arValid <= 1'h0;
      if (rValid) begin
        b = 1'h1;
        d = rData;
        r = rResp;
        rReady <= 1'h0;
      end
    end
  endtask

  // Two edges of pipeline plus margin before looking at the enables
  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask

  // Check the whole enable vector after channel 0 changes
  task automatic en0(input logic b);
    settle();
    expVec[0] = b;
    chk(32'(cancelEn), 32'(expVec));
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'h1;
    clkEn = 1'h1;
    tones = 3'h0;
    dataTone = 1'h0;
    sysFault = 1'h0;
    holdActive = 1'h0;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    awAddr = 8'h00;
    arAddr = 8'h00;
    wData = 32'h0000_0000;
    expVec = 24'h00_0000;
    repeat (10) @(posedge clk_sys);
    reset <= 1'h0;
    // Register reset values
    foreach (rstOffs[i]) begin
      axiRd(rstOffs[i], rd, resp);
      chk(rd, pcce_pkg::CtrlReset);
    end
    // Monitor table: every mode, card type, idle byte and combining option
    foreach (rows[i]) begin
      axiWr(pcce_pkg::OffCtrl, {16'h0000, rows[i].ctrl}, resp);
      u_pcce_t1_partner.sendSample(rows[i].ch[4:0], rows[i].sa[1:0], rows[i].ra[1:0], rows[i].sb, rows[i].rb,
                                   1'h0);
      settle();
      expVec[rows[i].ch[4:0]] = rows[i].en[0];
      chk(32'(cancelEn), 32'(expVec));
      chk(32'(selfTestRun[rows[i].ch[4:0]]), 32'(!rows[i].en[0]));
    end
    // Command on an idle-code channel in idle-code mode
    u_pcce_t1_partner.sendCcs(5'h08, 1'h1);
    settle();
    expVec[8] = 1'h1;
    chk(32'(cancelEn), 32'(expVec));
    // Priority ladder on channel 0
    axiWr(pcce_pkg::OffCtrl, 32'h0000_0000, resp);
    chk(32'(resp), 32'h0);
    u_pcce_t1_partner.sendSample(5'h00, 2'h3, 2'h3, 8'h00, 8'h00, 1'h0);
    en0(1'h1);
    axiWr(pcce_pkg::OffForceByp, 32'h0000_0001, resp);
    en0(1'h0);
    axiWr(pcce_pkg::OffForceByp, 32'h0000_0000, resp);
    en0(1'h1);
    axiWr(pcce_pkg::OffManDis, 32'h0000_0001, resp);
    en0(1'h0);
    axiWr(pcce_pkg::OffManDis, 32'h0000_0000, resp);
    en0(1'h1);
    u_pcce_t1_partner.sendCcs(5'h00, 1'h0);
    en0(1'h0);
    axiWr(pcce_pkg::OffForceAct, 32'h0000_0001, resp);
    en0(1'h1);
    @(posedge clk_sys);
    dataTone <= 1'h1;
    // A tone silences every channel, the commanded one too
    settle();
    chk(32'(cancelEn), 32'h0);
    @(posedge clk_sys);
    dataTone <= 1'h0;
    en0(1'h1);
    // Each signaling tone disables; forced active restores when it stops
    axiWr(pcce_pkg::OffCtrl, 32'h0000_1000, resp);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      tones <= 3'h1 << i;
      settle();
      chk(32'(cancelEn), 32'h0);
      @(posedge clk_sys);
      tones <= 3'h0;
      en0(1'h1);
    end
    // Interrupt: status, mask, clear
    axiRd(pcce_pkg::OffIrqStat, rd, resp);
    chk(rd, 32'h0000_0003);
    chk(32'(irq), 32'h0);
    axiWr(pcce_pkg::OffIrqEn, 32'h0000_0002, resp);
    chk(32'(irq), 32'h1);
    axiWr(pcce_pkg::OffIrqClr, 32'h0000_0003, resp);
    axiRd(pcce_pkg::OffIrqStat, rd, resp);
    chk(rd, 32'h0000_0000);
    chk(32'(irq), 32'h0);
    // Unmapped read, read-only write, control read back
    axiRd(8'h2C, rd, resp);
    chk(32'(resp), 32'h2);
    axiWr(pcce_pkg::OffEnState, 32'h0000_0001, resp);
    chk(32'(resp), 32'h2);
    axiRd(pcce_pkg::OffCtrl, rd, resp);
    chk(rd, 32'h0000_1000);
    // System fault: bypass, then alarm, then alarm held off by hold
    @(posedge clk_sys);
    sysFault <= 1'h1;
    settle();
    chk(32'(cancelEn), 32'h0);
    chk(32'(chanBypass), 32'h00FF_FFFF);
    chk(32'(aisOut), 32'h0);
    axiWr(pcce_pkg::OffCtrl, 32'h0000_1800, resp);
    settle();
    chk(32'(aisOut), 32'h1);
    @(posedge clk_sys);
    holdActive <= 1'h1;
    u_pcce_t1_partner.sendSample(5'h03, 2'h0, 2'h0, 8'h00, 8'h00, 1'h1);
    settle();
    chk(32'(aisOut), 32'h0);
    chk(32'(chanBypass[3]), 32'h1);
    axiRd(pcce_pkg::OffIrqStat, rd, resp);
    chk(32'(rd[2]), 32'h1);
    // Clock enable low freezes the outputs although the fault has gone
    @(posedge clk_sys);
    clkEn <= 1'h0;
    sysFault <= 1'h0;
    settle();
    chk(32'(chanBypass[3]), 32'h1);
    clkEn <= 1'h1;
    // Second reset in mid-run clears alarm, interrupt, enables and bypass
    @(posedge clk_sys);
    reset <= 1'h1;
    sysFault <= 1'h0;
    holdActive <= 1'h0;
    repeat (10) @(posedge clk_sys);
    chk({aisOut, irq, cancelEn, chanBypass[5:0]}, 32'h0);
    reset <= 1'h0;
    settle();
    chk({aisOut, irq, cancelEn, chanBypass[5:0]}, 32'h0);
    report_and_stop();
  end
endmodule // tb_per_channel_canceller_enable_control
